// *** include/strc_regs.svh ***
// What this block does
// R1 - Receive interrupt posts nine bit times after start.
// R2 - Next start accepted soon after the post.
// R3 - Software allows average gap less fifteen percent.
// R4 - Read within gap gives normal reception, code 4.
// R5 - Unread data forces overrun, keeps data, code 2.
// R6 - Read still needed after code 2.
// R7 - Normal plus overrun pending presents code 6.
// R8 - Reset clears all; shift register and synchronised receive pins become ones.
// R9 - No parity or framing checks performed.
// R10 - Input select low bits pick receive source.
// R11 - Input select top bit inverts mark polarity, except in loop mode.
// R12 - No straps means contact sense, closed mark.
// R13 - Rate strap code selects bit rate.
// R14 - No rate straps means 110 bits per second.
// R15 - Eight straps form the device address.
// R16 - Load straps enable program load boot.
// R17 - Transmit data drives all outputs together.
// R18 - Start while data unread begins overrun.
// R19 - Exception before device end; device end stays.
// R20 - One or two stop bits both accepted.
// R21 - Divided clock, start edge, mid-bit sampling.
`ifndef STRC_REGS_SVH
`define STRC_REGS_SVH

`define STRC_CLK_HZ 125000000
`define STRC_OVERSAMPLE 16
`define STRC_MID_TICK 4'h7
`define STRC_LAST_TICK 4'hF
`define STRC_HALF_TICKS 4'h8
`define STRC_RX_OP_BITS 9
`define STRC_RX_GAP_BITS 2
`define STRC_TX_FRAME_BITS 4'hB
`define STRC_TX_DONE_BITS 4'h9

`define STRC_ADDR_RXDATA 12'h000
`define STRC_ADDR_STATUS 12'h004
`define STRC_ADDR_INTACC 12'h008
`define STRC_ADDR_STRAPS 12'h00C
`define STRC_ADDR_TXDATA 12'h010

`define STRC_ST_ATTN 0
`define STRC_ST_EXC 1
`define STRC_ST_DEVEND 2
`define STRC_ST_RXBUSY 3
`define STRC_ST_OVERRUN 4
`define STRC_ST_LOADED 5
`define STRC_ST_READ 6
`define STRC_ST_TXBUSY 7

`define STRC_SP_SEL_LSB 0
`define STRC_SP_RATE_LSB 4
`define STRC_SP_ADDR_LSB 8
`define STRC_SP_LOAD_LSB 16

`define STRC_CC_NONE 3'h0
`define STRC_CC_EXC 3'h2
`define STRC_CC_DEVEND 3'h3
`define STRC_CC_ATTN 3'h4
`define STRC_CC_ATTN_EXC 3'h6
`define STRC_CC_ATTN_DEVEND 3'h7

`define STRC_RX_SHIFT_RST 8'hFF
`define STRC_RXDATA_RST 8'h00
`define STRC_SYNC_RST 20'h00007

`define STRC_SRC_CONTACT 2'h0
`define STRC_SRC_TTL 2'h1
`define STRC_SRC_EIA 2'h2
`define STRC_SRC_LOOP 2'h3

`endif

// *** include/strc_pkg.sv ***
package strc_pkg;
   typedef logic [3:0] strc_rate_t;
   typedef logic [2:0] strc_cc_t;
   typedef logic [7:0] strc_byte_t;
   typedef enum logic [1:0] {
      RX_IDLE,
      RX_START,
      RX_DATA,
      RX_STOP
   } strc_rx_state_t;
endpackage

// *** src/strc_bit_timer.sv ***
`timescale 1ns/10ps
`include "strc_regs.svh"
module strc_bit_timer #(
   parameter int unsigned CLK_HZ = `STRC_CLK_HZ
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire strc_pkg::strc_rate_t rate_code_i,
   output logic tick_o
);
   import strc_pkg::*;

   // Cycles per oversample tick for each rate code; reserved codes run at 110.
   function automatic int unsigned ticks_for(input strc_rate_t code);
      int unsigned bits_per_second;
      bits_per_second = 110;
      case (code)
         4'h4: bits_per_second = 50;
         4'h5: bits_per_second = 100;
         4'h6: bits_per_second = 200;
         4'h8: bits_per_second = 75;
         4'h9: bits_per_second = 150;
         4'hA: bits_per_second = 300;
         4'hB: bits_per_second = 600;
         4'hC: bits_per_second = 1200;
         4'hD: bits_per_second = 2400;
         4'hE: bits_per_second = 4800;
         4'hF: bits_per_second = 9600;
         default: bits_per_second = 110;
      endcase
      ticks_for = CLK_HZ / (bits_per_second * `STRC_OVERSAMPLE);
      if (ticks_for == 0) begin
         ticks_for = 1;
      end
   endfunction

   logic [23:0] cnt_q;
   wire [23:0] limit = 24'(ticks_for(rate_code_i) - 1);
   // R13 rate divider
   wire wrap = (cnt_q >= limit);

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= 24'h000000;
         tick_o <= 1'b0;
      end else begin
         cnt_q <= wrap ? 24'h000000 : cnt_q + 24'h000001;
         tick_o <= wrap;
      end
   end
endmodule

// *** src/strc_rx_deser.sv ***
`timescale 1ns/10ps
`include "strc_regs.svh"
module strc_rx_deser (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic tick_i,
   input wire logic mark_i,
   output logic start_o,
   output logic done_o,
   output logic busy_o,
   output strc_pkg::strc_byte_t data_o
);
   import strc_pkg::*;

   strc_rx_state_t state_q;
   logic [3:0] tick_cnt_q;
   logic [2:0] bit_cnt_q;
   strc_byte_t shift_q;

   wire tick_end = tick_i && (tick_cnt_q == `STRC_LAST_TICK);
   wire start_mid = tick_i && (tick_cnt_q == `STRC_MID_TICK);
   wire stop_post = tick_i && (tick_cnt_q == `STRC_MID_TICK);

   assign busy_o = (state_q != RX_IDLE);
   assign data_o = shift_q;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= RX_IDLE;
         tick_cnt_q <= 4'h0;
         bit_cnt_q <= 3'h0;
         // R8 shift register to ones
         shift_q <= `STRC_RX_SHIFT_RST;
         start_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         start_o <= 1'b0;
         done_o <= 1'b0;
         if (tick_i) begin
            tick_cnt_q <= tick_cnt_q + 4'h1;
         end
         case (state_q)
            RX_IDLE: begin
               // R21 start edge detect
               if (!mark_i) begin
                  state_q <= RX_START;
                  tick_cnt_q <= 4'h0;
                  start_o <= 1'b1;
               end
            end
            RX_START: begin
               // R9 no start validation
               if (start_mid) begin
                  state_q <= RX_DATA;
                  tick_cnt_q <= 4'h0;
                  bit_cnt_q <= 3'h0;
               end
            end
            RX_DATA: begin
               // R21 mid-bit sampling
               if (tick_end) begin
                  shift_q <= {mark_i, shift_q[7:1]};
                  bit_cnt_q <= bit_cnt_q + 3'h1;
                  if (bit_cnt_q == 3'h7) begin
                     state_q <= RX_STOP;
                     tick_cnt_q <= 4'h0;
                  end
               end
            end
            RX_STOP: begin
               // R1 post at nine bit times
               if (stop_post) begin
                  done_o <= 1'b1;
               end
               // R20 rehunt from stop midpoint
               if (tick_i && tick_cnt_q == `STRC_LAST_TICK) begin
                  state_q <= RX_IDLE;
               end
            end
            default: begin
               state_q <= RX_IDLE;
            end
         endcase
      end
   end
endmodule

// *** src/strc_adapter.sv ***
`timescale 1ns/10ps
`include "strc_regs.svh"
module strc_adapter #(
   parameter int unsigned CLK_HZ = `STRC_CLK_HZ
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic rx_contact_i,
   input wire logic rx_ttl_i,
   input wire logic rx_eia_i,
   input wire logic [2:0] strap_input_sel_i,
   input wire strc_pkg::strc_rate_t strap_rate_i,
   input wire logic [7:0] strap_addr_i,
   input wire logic [1:0] strap_load_i,
   output logic tx_current_o,
   output logic tx_sss_o,
   output logic tx_eia_o,
   output logic [7:0] device_address_o,
   output logic program_load_boot_en_o,
   output logic interrupt_request_o,
   output strc_pkg::strc_cc_t interrupt_condition_code_o
);
   import strc_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   localparam int PIN_W = 20;
   wire [PIN_W-1:0] pins = {strap_load_i, strap_addr_i, strap_rate_i, strap_input_sel_i,
                            rx_eia_i, rx_ttl_i, rx_contact_i};
   logic [PIN_W-1:0] sync1_q;
   logic [PIN_W-1:0] sync2_q;

   // Receive pins leave reset at mark, so no false start follows it.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_q <= `STRC_SYNC_RST;
         sync2_q <= `STRC_SYNC_RST;
      end else begin
         sync1_q <= pins;
         sync2_q <= sync1_q;
      end
   end

   wire [2:0] raw_rx = sync2_q[2:0];
   wire [2:0] sel = sync2_q[5:3];
   wire [3:0] rate = sync2_q[9:6];
   wire [7:0] addr = sync2_q[17:10];
   wire [1:0] load = sync2_q[19:18];

   // ----------------------------------------------------------------
   // Receive source selection
   // ----------------------------------------------------------------
   logic tx_line_q;
   // R10 source select
   wire src_contact = (sel[1:0] == `STRC_SRC_CONTACT);
   wire src_ttl = (sel[1:0] == `STRC_SRC_TTL);
   wire src_eia = (sel[1:0] == `STRC_SRC_EIA);
   wire raw_sel = src_contact ? raw_rx[0] : src_ttl ? raw_rx[1] : src_eia ? raw_rx[2] : 1'b0;
   // Loop mode takes the transmit line as is, whatever the polarity.
   // R11 polarity invert
   // R12 zero code is closed contact mark
   wire rx_mark = (sel[1:0] == `STRC_SRC_LOOP) ? tx_line_q : (raw_sel ^ sel[2]);

   // ----------------------------------------------------------------
   // Timing and deserialiser
   // ----------------------------------------------------------------
   logic tick;
   logic rx_start;
   logic rx_done;
   logic rx_busy;
   strc_byte_t rx_shift;

   // R14 default rate
   strc_bit_timer #(.CLK_HZ(CLK_HZ)) u_timer (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .rate_code_i(rate),
      .tick_o(tick)
   );

   strc_rx_deser u_deser (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .tick_i(tick),
      .mark_i(rx_mark),
      .start_o(rx_start),
      .done_o(rx_done),
      .busy_o(rx_busy),
      .data_o(rx_shift)
   );

   // ----------------------------------------------------------------
   // Register bus decode
   // ----------------------------------------------------------------
   wire setup = psel_i && !penable_i;
   wire access = psel_i && penable_i;
   wire hit_rx = (paddr_i == `STRC_ADDR_RXDATA);
   wire hit_st = (paddr_i == `STRC_ADDR_STATUS);
   wire hit_acc = (paddr_i == `STRC_ADDR_INTACC);
   wire hit_sp = (paddr_i == `STRC_ADDR_STRAPS);
   wire hit_tx = (paddr_i == `STRC_ADDR_TXDATA);
   wire mapped = hit_rx | hit_st | hit_acc | hit_sp | hit_tx;
   wire rd_rx_now = access && !pwrite_i && hit_rx;
   wire rd_acc_now = access && !pwrite_i && hit_acc;
   wire wr_tx_now = access && pwrite_i && hit_tx;

   // Every register answers at once, so no wait state is inserted.
   assign pready_o = 1'b1;

   // ----------------------------------------------------------------
   // Receive operation state
   // ----------------------------------------------------------------
   logic attn_q;
   logic exc_q;
   logic devend_q;
   logic overrun_q;
   logic loaded_q;
   logic read_q;
   strc_byte_t rxdata_q;
   logic [2:0] acc_clr_q;
   logic tx_devend;
   logic tx_busy_q;

   // Presentation code; exception outranks device end.
   function automatic strc_cc_t present_code(input logic attn, input logic exc,
                                             input logic devend);
      present_code = `STRC_CC_NONE;
      if (exc) begin
         present_code = attn ? `STRC_CC_ATTN_EXC : `STRC_CC_EXC;
      end else if (attn) begin
         present_code = devend ? `STRC_CC_ATTN_DEVEND : `STRC_CC_ATTN;
      end else if (devend) begin
         present_code = `STRC_CC_DEVEND;
      end
   endfunction

   // Flags that an accept clears: bit 0 attention, 1 exception, 2 device end.
   function automatic logic [2:0] accept_mask(input logic attn, input logic exc,
                                              input logic devend);
      accept_mask = exc ? {1'b0, 1'b1, attn} : {devend, 1'b0, attn};
   endfunction

   // R19 exception precedes device end
   // R7 combined code
   wire strc_cc_t cc_now = present_code(attn_q, exc_q, devend_q);
   // R19 device end kept on exception
   wire [2:0] clr_now = accept_mask(attn_q, exc_q, devend_q);
   wire [2:0] clr = rd_acc_now ? acc_clr_q : 3'h0;
   // The overrun choice is made at the start edge; a read then counts.
   // R18 overrun when loaded data unread
   wire overrun_start = loaded_q && !(read_q || rd_rx_now);
   wire normal_done = rx_done && !overrun_q;
   // R5 overrun completion
   wire exc_set = rx_done && overrun_q;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         attn_q <= 1'b0;
         exc_q <= 1'b0;
         devend_q <= 1'b0;
         overrun_q <= 1'b0;
         loaded_q <= 1'b0;
         read_q <= 1'b0;
         rxdata_q <= `STRC_RXDATA_RST;
      end else begin
         // R4 normal completion posts attention
         attn_q <= normal_done | (attn_q & ~clr[0]);
         exc_q <= exc_set | (exc_q & ~clr[1]);
         devend_q <= tx_devend | (devend_q & ~clr[2]);
         // R2 any start after the stop midpoint is taken
         // R6 outcome depends only on loaded and read state
         if (rx_start) begin
            overrun_q <= overrun_start;
         end
         // A load in the cycle of a read wins, so the new character counts unread.
         // R5 old data kept on overrun
         if (normal_done) begin
            rxdata_q <= rx_shift;
            loaded_q <= 1'b1;
            read_q <= 1'b0;
         end else if (rd_rx_now) begin
            read_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Transmit serialiser
   // ----------------------------------------------------------------
   logic [10:0] tx_shift_q;
   logic [3:0] tx_tick_q;
   logic [3:0] tx_bits_q;
   wire tx_bit_end = tick && (tx_tick_q == `STRC_LAST_TICK);

   // Two stop bits go out; device end is posted after nine bits.
   assign tx_devend = tx_busy_q && tx_bit_end && (tx_bits_q == (`STRC_TX_DONE_BITS - 4'h1));

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_busy_q <= 1'b0;
         tx_shift_q <= 11'h000;
         tx_tick_q <= 4'h0;
         tx_bits_q <= 4'h0;
         tx_line_q <= 1'b0;
      end else begin
         if (!tx_busy_q) begin
            tx_line_q <= 1'b1;
            if (wr_tx_now) begin
               tx_busy_q <= 1'b1;
               tx_shift_q <= {2'b11, pwdata_i[7:0], 1'b0};
               tx_tick_q <= 4'h0;
               tx_bits_q <= 4'h0;
            end
         end else begin
            tx_line_q <= tx_shift_q[0];
            if (tick) begin
               tx_tick_q <= tx_tick_q + 4'h1;
            end
            if (tx_bit_end) begin
               tx_shift_q <= {1'b1, tx_shift_q[10:1]};
               tx_bits_q <= tx_bits_q + 4'h1;
               if (tx_bits_q == (`STRC_TX_FRAME_BITS - 4'h1)) begin
                  tx_busy_q <= 1'b0;
               end
            end
         end
      end
   end

   // R17 all outputs in parallel
   assign tx_current_o = tx_line_q;
   assign tx_sss_o = tx_line_q;
   assign tx_eia_o = tx_line_q;

   // ----------------------------------------------------------------
   // Read data and straps
   // ----------------------------------------------------------------
   logic [31:0] status_w;
   logic [31:0] straps_w;
   logic [31:0] rd_mux;

   always_comb begin
      status_w = 32'h00000000;
      status_w[`STRC_ST_ATTN] = attn_q;
      status_w[`STRC_ST_EXC] = exc_q;
      status_w[`STRC_ST_DEVEND] = devend_q;
      status_w[`STRC_ST_RXBUSY] = rx_busy;
      // The overrun bit shows only while the overrun frame still runs.
      status_w[`STRC_ST_OVERRUN] = overrun_q && rx_busy;
      status_w[`STRC_ST_LOADED] = loaded_q;
      status_w[`STRC_ST_READ] = read_q;
      status_w[`STRC_ST_TXBUSY] = tx_busy_q;
      straps_w = 32'h00000000;
      straps_w[`STRC_SP_SEL_LSB +: 3] = sel;
      straps_w[`STRC_SP_RATE_LSB +: 4] = rate;
      straps_w[`STRC_SP_ADDR_LSB +: 8] = addr;
      straps_w[`STRC_SP_LOAD_LSB +: 2] = load;
      rd_mux = 32'h00000000;
      if (hit_rx) begin
         rd_mux = {24'h000000, rxdata_q};
      end else if (hit_st) begin
         rd_mux = status_w;
      end else if (hit_acc) begin
         rd_mux = {29'h00000000, cc_now};
      end else if (hit_sp) begin
         rd_mux = straps_w;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prdata_o <= 32'h00000000;
         pslverr_o <= 1'b0;
         acc_clr_q <= 3'h0;
         device_address_o <= 8'h00;
         program_load_boot_en_o <= 1'b0;
         interrupt_request_o <= 1'b0;
         interrupt_condition_code_o <= `STRC_CC_NONE;
      end else begin
         // Read data is caught at the setup edge and stands through the access.
         if (setup) begin
            prdata_o <= pwrite_i ? 32'h00000000 : rd_mux;
            pslverr_o <= !mapped;
            acc_clr_q <= clr_now;
         end
         // R15 device address
         device_address_o <= addr;
         // R16 load enable
         program_load_boot_en_o <= |load;
         interrupt_request_o <= attn_q | exc_q | devend_q;
         interrupt_condition_code_o <= cc_now;
      end
   end
endmodule

// *** verif/strc_adapter_monitor.sv ***
`timescale 1ns/10ps
module strc_adapter_monitor (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pslverr_o,
   input wire logic [7:0] strap_addr_i,
   input wire logic [1:0] strap_load_i,
   input wire logic tx_current_o,
   input wire logic tx_sss_o,
   input wire logic tx_eia_o,
   input wire logic [7:0] device_address_o,
   input wire logic program_load_boot_en_o,
   input wire logic interrupt_request_o,
   input wire strc_pkg::strc_cc_t interrupt_condition_code_o
);
   import strc_pkg::*;
   // ----------------------------------------
   // Cycles since reset and accept decode
   // ----------------------------------------
   logic [2:0] up_q;
   logic acc_rd;
   assign acc_rd = psel_i && penable_i && paddr_i == 12'h008;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         up_q <= 3'h0;
      end else if (up_q != 3'h7) begin
         up_q <= up_q + 3'h1;
      end
   end
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);
   AST_RST_VAL: assert property (
      up_q == 3'h0 |-> !interrupt_request_o && !tx_current_o && device_address_o == 8'h00
      && interrupt_condition_code_o == 3'h0 ##1 tx_current_o) else $error("bad reset state");
   AST_ADDR_STRAPS: assert property (
      (up_q == 3'h7 && $stable(strap_addr_i)) [*4] |-> device_address_o == strap_addr_i)
      else $error("address does not follow straps");
   AST_LOAD_STRAPS: assert property (
      (up_q == 3'h7 && $stable(strap_load_i)) [*4] |-> program_load_boot_en_o == |strap_load_i)
      else $error("boot enable does not follow straps");
   AST_TX_SAME: assert property (
      tx_sss_o == tx_current_o && tx_eia_o == tx_current_o) else $error("tx outputs differ");
   AST_IRQ_CC: assert property (
      interrupt_request_o == (interrupt_condition_code_o != 3'h0)) else $error("irq and code");
   AST_CC_LEGAL: assert property (
      interrupt_condition_code_o inside {3'h0, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7})
      else $error("illegal condition code");
   AST_SLVERR: assert property (
      psel_i && penable_i |-> pslverr_o == !(paddr_i inside {12'h000, 12'h004, 12'h008,
      12'h00C, 12'h010})) else $error("wrong slave error");
   AST_ACC_ATTN: assert property (
      acc_rd && prdata_o[2:0] == 3'h4 |-> ##[1:2] interrupt_condition_code_o == 3'h0)
      else $error("attention not cleared by accept");
   AST_ACC_EXC: assert property (
      acc_rd && prdata_o[1] |-> ##[1:2] interrupt_condition_code_o inside {3'h0, 3'h3})
      else $error("exception not cleared by accept");
   cover property ($rose(interrupt_request_o));
   cover property (interrupt_condition_code_o == 3'h6);
   cover property (interrupt_condition_code_o == 3'h7);
endmodule

// *** verif/strc_term_model.sv ***
`timescale 1ns/10ps
module strc_term_model (
   input wire logic clock_i,
   input wire logic [2:0] sel_i,
   output logic rx_contact_o,
   output logic rx_ttl_o,
   output logic rx_eia_o
);
   logic line_q = 1'b1;
   logic noise_q = 1'b0;
   logic pin;
   // Unused lines toggle so a wrong source pick garbles data.
   always @(posedge clock_i) begin
      noise_q <= ~noise_q;
   end
   assign pin = line_q ^ sel_i[2];
   assign rx_contact_o = sel_i[1:0] == 2'h0 ? pin : noise_q;
   assign rx_ttl_o = sel_i[1:0] == 2'h1 ? pin : noise_q;
   assign rx_eia_o = sel_i[1:0] == 2'h2 ? pin : noise_q;
   task automatic send(input logic [7:0] b, input int nstop, input int bit_clks);
      logic [10:0] f;
      f = {2'b11, b, 1'b0};
      for (int i = 0; i < 9 + nstop; i++) begin
         line_q <= f[i];
         repeat (bit_clks) @(posedge clock_i);
      end
   endtask
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/10ps
module testbench;
   import strc_pkg::*;
   localparam int unsigned CLK_HZ = 153600;
   localparam int BIT = 128;
   logic clock_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic rx_contact_i, rx_ttl_i, rx_eia_i, tx_current_o, tx_sss_o, tx_eia_o;
   logic program_load_boot_en_o, interrupt_request_o;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, r;
   logic [2:0] strap_input_sel_i;
   logic [7:0] strap_addr_i, device_address_o;
   logic [1:0] strap_load_i;
   strc_rate_t strap_rate_i;
   strc_cc_t interrupt_condition_code_o;
   int n_errors = 0;
   int n_checks = 0;
   strc_adapter #(.CLK_HZ(CLK_HZ)) DUT (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_contact_i(rx_contact_i),
      .rx_ttl_i(rx_ttl_i), .rx_eia_i(rx_eia_i), .strap_input_sel_i(strap_input_sel_i),
      .strap_rate_i(strap_rate_i), .strap_addr_i(strap_addr_i), .strap_load_i(strap_load_i),
      .tx_current_o(tx_current_o), .tx_sss_o(tx_sss_o), .tx_eia_o(tx_eia_o),
      .device_address_o(device_address_o), .program_load_boot_en_o(program_load_boot_en_o),
      .interrupt_request_o(interrupt_request_o),
      .interrupt_condition_code_o(interrupt_condition_code_o));
   strc_term_model term (.clock_i(clock_i), .sel_i(strap_input_sel_i),
      .rx_contact_o(rx_contact_i), .rx_ttl_o(rx_ttl_i), .rx_eia_o(rx_eia_i));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      @(posedge clock_i);
      while (pready_o !== 1'b1) begin
         @(posedge clock_i);
      end
      r = prdata_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clock_i);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(r, exp);
   endtask
   task automatic wait_irq(output int n);
      for (n = 0; n < 5000 && interrupt_request_o !== 1'b1; n++) @(posedge clock_i);
      chk(interrupt_request_o, 32'h1);
   endtask
   task automatic setup(input logic [2:0] s, input strc_rate_t rc);
      strap_input_sel_i <= s;
      strap_rate_i <= rc;
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (6) @(posedge clock_i);
   endtask
   task automatic rx_char(input logic [7:0] b, output int n);
      fork
         term.send(b, 1, BIT);
         wait_irq(n);
      join
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_basics();
      rd(12'h004, 32'h0);
      rd(12'h000, 32'h0);
      rd(12'h008, 32'h0);
      chk(program_load_boot_en_o, 32'h0);
      rd(12'h014, 32'h0);
      chk(pslverr_o, 32'h1);
      strap_addr_i <= 8'hA5;
      strap_load_i <= 2'h2;
      repeat (5) @(posedge clock_i);
      chk(device_address_o, 32'hA5);
      chk(program_load_boot_en_o, 32'h1);
      rd(12'h00C, 32'h0002A500);
   endtask
   task automatic t_rates();
      int rt[16] = '{110, 110, 110, 110, 50, 100, 200, 110, 75, 150, 300, 600, 1200, 2400,
         4800, 9600};
      int n, e;
      for (int c = 0; c < 16; c++) begin
         setup(3'h0, c[3:0]);
         e = CLK_HZ / rt[c];
         apb(1'b1, 12'h010, 32'hFF);
         for (n = 0; n < 4000 && tx_current_o !== 1'b0; n++) @(posedge clock_i);
         for (n = 0; n < 4000 && tx_current_o === 1'b0; n++) @(posedge clock_i);
         chk(n >= e - e / 16 - 2 && n <= e + e / 16 + 2, 32'h1);
      end
   endtask
   task automatic t_sources();
      int n;
      for (int s = 0; s < 7; s++) begin
         if (s != 3) begin
            setup(s[2:0], 4'hC);
            rx_char({5'h10, s[2:0]}, n);
            chk(n >= 9 * BIT && n <= 9 * BIT + BIT / 16 + 6, 32'h1);
            rd(12'h008, 32'h4);
            rd(12'h000, {24'h0, 5'h10, s[2:0]});
         end
      end
   endtask
   task automatic t_loop();
      for (int s = 3; s < 8; s += 4) begin
         setup(s[2:0], 4'hC);
         apb(1'b1, 12'h010, 32'h5A);
         repeat (13 * BIT) @(posedge clock_i);
         rd(12'h008, 32'h7);
         rd(12'h008, 32'h0);
         rd(12'h000, 32'h5A);
      end
   endtask
   task automatic t_overrun();
      int n;
      setup(3'h0, 4'hC);
      rx_char(8'h11, n);
      rd(12'h008, 32'h4);
      rx_char(8'h22, n);
      rd(12'h004, 32'h22);
      rd(12'h008, 32'h2);
      rd(12'h000, 32'h11);
      rx_char(8'h33, n);
      rd(12'h008, 32'h4);
      rd(12'h000, 32'h33);
      rx_char(8'h44, n);
      rx_char(8'h55, n);
      rd(12'h008, 32'h6);
      rd(12'h000, 32'h44);
      fork
         begin
            term.send(8'h66, 2, BIT);
            term.send(8'h77, 1, BIT);
            term.send(8'h88, 1, BIT);
         end
         for (int k = 0; k < 3; k++) begin
            wait_irq(n);
            rd(12'h008, 32'h4);
            rd(12'h000, 32'h66 + 32'h11 * k);
         end
      join
   endtask
   // ----------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------
   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   initial begin
      repeat (60000) @(posedge clock_i);
      n_errors++;
      conclude();
   end
   initial begin
      rst_n_i = 1'b0;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 12'h000;
      pwdata_i = 32'h0;
      strap_input_sel_i = 3'h0;
      strap_rate_i = 4'h0;
      strap_addr_i = 8'h00;
      strap_load_i = 2'h0;
      repeat (16) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (6) @(posedge clock_i);
      t_basics();
      t_rates();
      t_sources();
      t_loop();
      t_overrun();
      conclude();
   end
endmodule
bind strc_adapter strc_adapter_monitor mon (
   .clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
   .paddr_i(paddr_i), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .strap_addr_i(strap_addr_i),
   .strap_load_i(strap_load_i), .tx_current_o(tx_current_o), .tx_sss_o(tx_sss_o),
   .tx_eia_o(tx_eia_o), .device_address_o(device_address_o),
   .program_load_boot_en_o(program_load_boot_en_o), .interrupt_request_o(interrupt_request_o),
   .interrupt_condition_code_o(interrupt_condition_code_o));
